/* File: design/alc_engine.sv */
// Automatic level control engine: limiter, recovery, fast recovery
`timescale 1ns/1ps
// Operation
// - Path-select 1 recording, 0 playback
// - Each path has own enable bit
// - Over detection level lowers shared volume
// - Zero-cross enabled: change at crossing/timeout
// - Fast limiter above full scale: instant one step
// - Zero-cross disabled: instant, single step
// - Keep attenuating while above detection level
// - Threshold field picks detection/reset levels
// - Attenuation step table by output level
// - Timeout 128 to 1024 sample periods
// - Recovery after quiet full waiting period
// - Recovery raises volume by gain step
// - One increment per wait or timeout
// - Never recover above reference level
// - Wait timer cleared in reset band
// - Waiting period 128 times two^code
// - Recovery gain 1 to 4 steps
// - Recording reference 8-bit, default E1H
// - Playback reference 6-bit, default 28H
// - Fast recovery 4x, 8x, 16x
// - Live volume readable by software
module alc_engine (
   // Clock and reset
   input  wire logic                                clk_sys_i,
   input  wire logic                                srst_i,
   // Register port
   input  wire logic [2:0]                          reg_addr_i,
   input  wire logic [7:0]                          reg_wdata_i,
   input  wire logic                                reg_wr_i,
   input  wire logic                                reg_rd_i,
   output logic      [7:0]                          reg_rdata_o,
   // Sample stream, one strobe per fs
   input  wire logic                                sample_valid_i,
   input  wire logic signed [alc_pkg::ALC_SMP_W-1:0] left_sample_i,
   input  wire logic signed [alc_pkg::ALC_SMP_W-1:0] right_sample_i,
   // Volume codes
   output logic      [7:0]                          rec_left_volume_o,
   output logic      [7:0]                          rec_right_volume_o,
   output logic      [7:0]                          play_left_volume_o,
   output logic      [7:0]                          play_right_volume_o
);

   typedef struct packed {
      logic [7:0]       ctrl;
      logic [7:0]       tune;
      logic [7:0]       waitc;
      logic [7:0]       rec_ref;
      logic [5:0]       play_ref;
      logic [7:0]       tgt;
      logic [1:0][7:0]  vol_l;
      logic [1:0][7:0]  vol_r;
      logic             sign_l;
      logic             sign_r;
      logic [10:0]      zc_cnt;
      logic [14:0]      wait_cnt;
      logic [7:0]       over_cnt;
      logic             limiting;
      logic             fast;
      logic [7:0]       rdata;
   } alc_state_t;

   alc_state_t s_q;
   alc_state_t s_d;

   function automatic logic [25:0] alc_mag(input logic signed [alc_pkg::ALC_SMP_W-1:0] v);
      logic [26:0] a;
      a = v[alc_pkg::ALC_SMP_W-1] ? 27'(-v) : 27'(v);
      return a[26] ? 26'h3FFFFFF : a[25:0];
   endfunction

   function automatic logic [7:0] alc_sub(input logic [7:0] v, input logic [3:0] st);
      return (v > {4'h0, st}) ? 8'(v - {4'h0, st}) : 8'h00;
   endfunction

   // Combinational helpers
   logic        path;
   logic        eng_en;
   logic [25:0] peak;
   logic [25:0] det_lvl;
   logic [25:0] rst_lvl;
   logic        over;
   logic        below;
   logic        over_fs;
   logic        pending;
   logic [3:0]  att_step;
   logic [3:0]  gain_step;
   logic [10:0] zto;
   logic [14:0] wait_per;
   logic [7:0]  ref_code;
   logic [7:0]  vl;
   logic [7:0]  vr;
   logic [7:0]  tgt_n;
   logic [8:0]  up;
   logic        zl;
   logic        zr;
   logic        to_hit;
   logic        vol_wr;

   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      path = s_q.ctrl[alc_pkg::ALC_CTRL_PATH];
      eng_en = path ? s_q.ctrl[alc_pkg::ALC_CTRL_REC_EN] : s_q.ctrl[alc_pkg::ALC_CTRL_PLAY_EN];
      peak = (alc_mag(left_sample_i) > alc_mag(right_sample_i)) ? alc_mag(left_sample_i)
                                                                 : alc_mag(right_sample_i);
      unique case (s_q.tune[alc_pkg::ALC_TUNE_THR +: 2])
         2'h0: begin
            det_lvl = alc_pkg::ALC_LVL_M2P5;
            rst_lvl = alc_pkg::ALC_LVL_M4P1;
         end
         2'h1: begin
            det_lvl = alc_pkg::ALC_LVL_M4P1;
            rst_lvl = alc_pkg::ALC_LVL_M6P0;
         end
         2'h2: begin
            det_lvl = alc_pkg::ALC_LVL_M6P0;
            rst_lvl = alc_pkg::ALC_LVL_M8P5;
         end
         2'h3: begin
            det_lvl = alc_pkg::ALC_LVL_M8P5;
            rst_lvl = alc_pkg::ALC_LVL_M12;
         end
      endcase
      over    = peak >= det_lvl;
      below   = peak < rst_lvl;
      over_fs = peak >= alc_pkg::ALC_LVL_FS;
      unique case (s_q.tune[alc_pkg::ALC_TUNE_ATT +: 2])
         2'h0: att_step = 4'h1;
         2'h1: att_step = 4'h2;
         2'h2: att_step = (peak >= alc_pkg::ALC_LVL_FS12) ? 4'h8 : over_fs ? 4'h4 : 4'h2;
         2'h3: att_step = (peak >= alc_pkg::ALC_LVL_FS12) ? 4'h8 :
                          (peak >= alc_pkg::ALC_LVL_FS6) ? 4'h4 : over_fs ? 4'h2 : 4'h1;
      endcase
      gain_step = {2'h0, s_q.tune[alc_pkg::ALC_TUNE_GAIN +: 2]} + 4'h1;
      zto = alc_pkg::ALC_ZTO_BASE << s_q.tune[alc_pkg::ALC_TUNE_ZTO +: 2];
      wait_per = alc_pkg::ALC_WAIT_BASE << s_q.waitc[alc_pkg::ALC_WAIT_SEL +: 3];
      // Fast recovery shortens the wait; the unavailable code acts as 4x
      if (s_q.fast) begin
         unique case (s_q.waitc[alc_pkg::ALC_WAIT_FAST +: 2])
            2'h1:    wait_per = wait_per >> 3;
            2'h2:    wait_per = wait_per >> 4;
            default: wait_per = wait_per >> 2;
         endcase
      end
      ref_code = path ? s_q.rec_ref
                      : 8'(alc_pkg::ALC_PLY_REF_OFS + {s_q.play_ref, 2'b00});
      vl = s_q.vol_l[path];
      vr = s_q.vol_r[path];
      pending = (vl != s_q.tgt) || (vr != s_q.tgt);
      zl = left_sample_i[alc_pkg::ALC_SMP_W-1] != s_q.sign_l;
      zr = right_sample_i[alc_pkg::ALC_SMP_W-1] != s_q.sign_r;
      to_hit = s_q.zc_cnt >= 11'(zto - 11'h001);
      tgt_n = s_q.tgt;
      up = 9'h000;
      vol_wr = reg_wr_i && (reg_addr_i == alc_pkg::ALC_OFS_VOLUME);

      if (sample_valid_i) begin
         s_d.sign_l = left_sample_i[alc_pkg::ALC_SMP_W-1];
         s_d.sign_r = right_sample_i[alc_pkg::ALC_SMP_W-1];
      end

      if (sample_valid_i && eng_en) begin
         if (over) begin
            s_d.wait_cnt = 15'h0000;
            s_d.limiting = 1'b1;
            s_d.over_cnt = (s_q.over_cnt == 8'hFF) ? 8'hFF : 8'(s_q.over_cnt + 8'h01);
            if (s_q.ctrl[alc_pkg::ALC_CTRL_ZC_DIS] ||
                (s_q.ctrl[alc_pkg::ALC_CTRL_FAST_LM] && over_fs)) begin
               tgt_n = alc_sub(s_q.tgt, 4'h1);
               vl = tgt_n;
               vr = tgt_n;
            end else if (!pending) begin
               tgt_n = alc_sub(s_q.tgt, att_step);
            end
         end else begin
            // Short bursts of limiting are treated as impulse noise
            if (s_q.limiting) begin
               s_d.limiting = 1'b0;
               s_d.over_cnt = 8'h00;
               s_d.fast = s_q.over_cnt <= alc_pkg::ALC_IMPULSE_MAX;
            end
            if (!below) begin
               s_d.wait_cnt = 15'h0000;
            end else if (s_q.wait_cnt >= 15'(wait_per - 15'h0001)) begin
               // Increment waits while a change is still pending
               if (!pending) begin
                  s_d.wait_cnt = 15'h0000;
                  if (s_q.tgt < ref_code) begin
                     up = {1'b0, s_q.tgt} + {5'h00, gain_step};
                     tgt_n = (up > {1'b0, ref_code}) ? ref_code : up[7:0];
                  end
                  if (tgt_n >= ref_code) begin
                     s_d.fast = 1'b0;
                  end
               end
            end else begin
               s_d.wait_cnt = 15'(s_q.wait_cnt + 15'h0001);
            end
         end
         // Each channel moves at its own crossing, both on timeout
         if (vl != tgt_n && (zl || to_hit)) begin
            vl = tgt_n;
         end
         if (vr != tgt_n && (zr || to_hit)) begin
            vr = tgt_n;
         end
         s_d.zc_cnt = (vl != tgt_n || vr != tgt_n) ? 11'(s_q.zc_cnt + 11'h001) : 11'h000;
         s_d.tgt = tgt_n;
         s_d.vol_l[path] = vl;
         s_d.vol_r[path] = vr;
      end

      if (reg_wr_i) begin
         unique case (reg_addr_i)
            alc_pkg::ALC_OFS_CTRL:    s_d.ctrl = reg_wdata_i;
            alc_pkg::ALC_OFS_TUNE:    s_d.tune = reg_wdata_i;
            alc_pkg::ALC_OFS_WAIT:    s_d.waitc = reg_wdata_i;
            alc_pkg::ALC_OFS_REC_REF: s_d.rec_ref = reg_wdata_i;
            alc_pkg::ALC_OFS_PLY_REF: s_d.play_ref = reg_wdata_i[5:0];
            default: ;
         endcase
      end
      // Seeding the volume restarts the active path from a known code
      if (vol_wr) begin
         s_d.tgt = reg_wdata_i;
         s_d.vol_l[path] = reg_wdata_i;
         s_d.vol_r[path] = reg_wdata_i;
         s_d.zc_cnt = 11'h000;
      end
      // Path change: the new path's left volume becomes the target
      if (reg_wr_i && reg_addr_i == alc_pkg::ALC_OFS_CTRL &&
          reg_wdata_i[alc_pkg::ALC_CTRL_PATH] != path) begin
         s_d.tgt = s_q.vol_l[reg_wdata_i[alc_pkg::ALC_CTRL_PATH]];
         s_d.zc_cnt = 11'h000;
      end

      if (reg_rd_i) begin
         unique case (reg_addr_i)
            alc_pkg::ALC_OFS_CTRL:    s_d.rdata = {3'h0, s_q.ctrl[4:0]};
            alc_pkg::ALC_OFS_TUNE:    s_d.rdata = s_q.tune;
            alc_pkg::ALC_OFS_WAIT:    s_d.rdata = {3'h0, s_q.waitc[4:0]};
            alc_pkg::ALC_OFS_REC_REF: s_d.rdata = s_q.rec_ref;
            alc_pkg::ALC_OFS_PLY_REF: s_d.rdata = {2'h0, s_q.play_ref};
            alc_pkg::ALC_OFS_VOLUME:  s_d.rdata = s_q.vol_l[path];
            alc_pkg::ALC_OFS_STATUS:  s_d.rdata = {5'h00, pending, s_q.fast, s_q.limiting};
            default:                  s_d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         s_q.ctrl     <= alc_pkg::ALC_CTRL_RST;
         s_q.tune     <= alc_pkg::ALC_TUNE_RST;
         s_q.waitc    <= alc_pkg::ALC_WAIT_RST;
         s_q.rec_ref  <= alc_pkg::ALC_REC_REF_RST;
         s_q.play_ref <= alc_pkg::ALC_PLY_REF_RST;
         s_q.tgt      <= alc_pkg::ALC_VOL_RST;
         s_q.vol_l    <= {alc_pkg::ALC_VOL_RST, alc_pkg::ALC_VOL_RST};
         s_q.vol_r    <= {alc_pkg::ALC_VOL_RST, alc_pkg::ALC_VOL_RST};
         s_q.sign_l   <= 1'b0;
         s_q.sign_r   <= 1'b0;
         s_q.zc_cnt   <= 11'h000;
         s_q.wait_cnt <= 15'h0000;
         s_q.over_cnt <= 8'h00;
         s_q.limiting <= 1'b0;
         s_q.fast     <= 1'b0;
         s_q.rdata    <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o         = s_q.rdata;
   assign rec_left_volume_o   = s_q.vol_l[1];
   assign rec_right_volume_o  = s_q.vol_r[1];
   assign play_left_volume_o  = s_q.vol_l[0];
   assign play_right_volume_o = s_q.vol_r[0];

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (srst_i);

   a_disabled_holds: assert property (
      (!eng_en && !reg_wr_i) |=> ($stable(s_q.vol_l) && $stable(s_q.vol_r) && $stable(s_q.tgt)))
      else $error("volume moved while level control disabled");

   a_idle_path_holds: assert property (
      (sample_valid_i && !reg_wr_i) |=> ($stable(s_q.vol_l[!path]) && $stable(s_q.vol_r[!path])))
      else $error("inactive path volume changed");

   a_limit_lowers: assert property (
      (sample_valid_i && eng_en && over && !pending && !reg_wr_i && s_q.tgt != 8'h00)
      |=> (s_q.tgt < $past(s_q.tgt)))
      else $error("limiter did not lower volume");

   a_zc_off_step: assert property (
      (sample_valid_i && eng_en && over && s_q.ctrl[alc_pkg::ALC_CTRL_ZC_DIS] && !reg_wr_i
       && s_q.tgt != 8'h00)
      |=> (s_q.tgt == 8'($past(s_q.tgt) - 8'h01) && s_q.vol_l[path] == s_q.tgt
           && s_q.vol_r[path] == s_q.tgt))
      else $error("zero-cross off limiter not instant single step");

   a_fast_limit_step: assert property (
      (sample_valid_i && eng_en && over_fs && s_q.ctrl[alc_pkg::ALC_CTRL_FAST_LM] && !reg_wr_i
       && s_q.tgt != 8'h00)
      |=> (s_q.tgt == 8'($past(s_q.tgt) - 8'h01) && s_q.vol_r[path] == s_q.tgt))
      else $error("fast limiter not instant single step");

   a_ref_ceiling: assert property (
      (sample_valid_i && eng_en && !over && !reg_wr_i)
      |=> (s_q.tgt <= $past(s_q.tgt) || s_q.tgt <= ref_code))
      else $error("recovery passed reference level");

   a_wait_cleared: assert property (
      (sample_valid_i && eng_en && !below) |=> (s_q.wait_cnt == 15'h0000))
      else $error("wait timer not cleared in reset band");

   a_recover_step: assert property (
      (sample_valid_i && eng_en && !over && !reg_wr_i)
      |=> ({1'b0, s_q.tgt} <= {1'b0, $past(s_q.tgt)} + {5'h00, $past(gain_step)}))
      else $error("recovery step larger than gain setting");

   a_timeout_bound: assert property (
      s_q.zc_cnt < zto)
      else $error("zero crossing timeout overran");

   a_timeout_moves: assert property (
      (sample_valid_i && eng_en && to_hit && !reg_wr_i)
      |=> (s_q.zc_cnt == 11'h000 && s_q.vol_l[path] == s_q.tgt && s_q.vol_r[path] == s_q.tgt))
      else $error("timeout did not move both channels");

   a_wait_runs: assert property (
      (sample_valid_i && eng_en && !over && below && !reg_wr_i
       && s_q.wait_cnt < 15'(wait_per - 15'h0001))
      |=> (s_q.wait_cnt == 15'($past(s_q.wait_cnt) + 15'h0001)))
      else $error("wait timer did not run below reset level");

endmodule // alc_engine

/* File: dv/alc_sample_src.sv */
// Sample source standing in for the codec audio path
`timescale 1ns/1ps
module alc_sample_src (
   // Clock and reset
   input  wire logic               clk_sys_i,
   input  wire logic               srst_i,
   // Control from the bench
   input  wire logic               run_i,
   input  wire logic               alt_i,
   input  wire logic [25:0]        amp_i,
   // Sample stream
   output logic                    sample_valid_o,
   output logic signed [26:0]      left_o,
   output logic signed [26:0]      right_o
);
   logic [1:0] cnt_q;
   logic       neg_q;
   logic       fire;
   logic signed [26:0] smp;

   assign fire = run_i && (cnt_q == 2'h3);
   assign smp  = neg_q ? -$signed({1'b0, amp_i}) : $signed({1'b0, amp_i});

   // One strobe every fourth cycle keeps the long counts short
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cnt_q          <= 2'h0;
         neg_q          <= 1'b0;
         sample_valid_o <= 1'b0;
         left_o         <= 27'h0;
         right_o        <= 27'h0;
      end else begin
         cnt_q          <= cnt_q + 2'h1;
         sample_valid_o <= fire;
         if (fire) begin
            neg_q   <= alt_i ? ~neg_q : 1'b0;
            left_o  <= smp;
            right_o <= smp;
         end else begin
            // No sample outside a strobe, so the lines keep moving
            left_o  <= ~left_o;
            right_o <= ~right_o;
         end
      end
   end
endmodule // alc_sample_src

/* File: dv/tb_top.sv */
// Register-driven tests of the level control engine
`timescale 1ns/1ps
module tb_top;
   logic              clk_sys_i = 1'b0;
   logic              srst_i    = 1'b1;
   logic [2:0]        reg_addr_i  = 3'h0;
   logic [7:0]        reg_wdata_i = 8'h00;
   logic              reg_wr_i = 1'b0;
   logic              reg_rd_i = 1'b0;
   logic [7:0]        reg_rdata_o;
   logic              run = 1'b0;
   logic              alt = 1'b0;
   logic [25:0]       amp = 26'h0;
   logic              sample_valid_i;
   logic signed [26:0] left_sample_i;
   logic signed [26:0] right_sample_i;
   logic [7:0]        rec_left_volume_o;
   logic [7:0]        rec_right_volume_o;
   logic [7:0]        play_left_volume_o;
   logic [7:0]        play_right_volume_o;
   int                error_cnt = 0;
   int                cmp_count = 0;
   int                cyc       = 0;
   logic [25:0]       lvl [4];

   always #25 clk_sys_i = ~clk_sys_i;

   alc_engine alc_engine_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .sample_valid_i(sample_valid_i), .left_sample_i(left_sample_i), .right_sample_i(right_sample_i),
      .rec_left_volume_o(rec_left_volume_o), .rec_right_volume_o(rec_right_volume_o),
      .play_left_volume_o(play_left_volume_o), .play_right_volume_o(play_right_volume_o));

   alc_sample_src alc_sample_src_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .run_i(run), .alt_i(alt),
      .amp_i(amp), .sample_valid_o(sample_valid_i), .left_o(left_sample_i), .right_o(right_sample_i));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1;
      chk(reg_rdata_o, exp);
   endtask

   // Send n strobes at amplitude m, then let the volume update land
   task automatic send(input int n, input logic [25:0] m, input logic a);
      int k;
      k = 0;
      @(posedge clk_sys_i);
      amp <= m;
      alt <= a;
      run <= 1'b1;
      while (k < n) begin
         @(posedge clk_sys_i);
         #1;
         if (sample_valid_i === 1'b1) k++;
      end
      run <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic vols(input logic [7:0] r, input logic [7:0] p);
      chk(rec_left_volume_o, r);
      chk(rec_right_volume_o, r);
      chk(play_left_volume_o, p);
      chk(play_right_volume_o, p);
   endtask

   task automatic results;
      $display("Compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Ceiling well above the roughly 2100 cycles the tests need
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      lvl = '{alc_pkg::ALC_LVL_M2P5, alc_pkg::ALC_LVL_M4P1, alc_pkg::ALC_LVL_M6P0, alc_pkg::ALC_LVL_M8P5};
      repeat (10) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rd(3'h0, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h2, 8'h00);
      rd(3'h3, 8'hE1);
      rd(3'h4, 8'h28);
      rd(3'h5, 8'h91);
      wr(3'h7, 8'hFF);
      wr(3'h6, 8'hFF);
      rd(3'h7, 8'h00);
      rd(3'h6, 8'h00);
      $display("Test reset values done");
      // Quiet input, wait 128 samples, gain code 01 adds two steps
      wr(3'h0, 8'h03);
      wr(3'h1, 8'h40);
      wr(3'h5, 8'h80);
      send(120, 26'h0001000, 1'b1);
      vols(8'h80, 8'h91);
      send(16, 26'h0001000, 1'b1);
      vols(8'h82, 8'h91);
      rd(3'h5, 8'h82);
      // Gain of four steps from E0 stops at reference E1
      wr(3'h1, 8'hC0);
      wr(3'h5, 8'hE0);
      send(140, 26'h0001000, 1'b1);
      vols(8'hE1, 8'h91);
      $display("Test recovery done");
      // Threshold codes with zero cross off and step code 01
      for (int i = 0; i < 4; i++) begin
         wr(3'h0, 8'h0B);
         wr(3'h1, 8'(i + 4));
         wr(3'h5, 8'h91);
         send(1, lvl[i] - 26'h1, 1'b0);
         vols(8'h91, 8'h91);
         send(1, lvl[i], 1'b0);
         vols(8'h90, 8'h91);
      end
      // Playback path, three limiting strobes in a row
      wr(3'h0, 8'h0C);
      send(3, alc_pkg::ALC_LVL_M2P5, 1'b0);
      vols(8'h90, 8'h8E);
      wr(3'h0, 8'h08);
      send(2, alc_pkg::ALC_LVL_FS, 1'b0);
      vols(8'h90, 8'h8E);
      $display("Test limiter done");
      // Fast limiter above full scale takes one step at once
      wr(3'h0, 8'h14);
      wr(3'h1, 8'h0C);
      send(1, alc_pkg::ALC_LVL_FS + 26'h1, 1'b0);
      vols(8'h90, 8'h8D);
      // Zero cross on, no crossing: change waits for 128 samples
      wr(3'h0, 8'h04);
      wr(3'h1, 8'h00);
      send(64, alc_pkg::ALC_LVL_M2P5, 1'b0);
      vols(8'h90, 8'h8D);
      rd(3'h6, 8'h07);
      send(76, alc_pkg::ALC_LVL_M2P5, 1'b0);
      vols(8'h90, 8'h8C);
      // Step code 10 at FS+6dB: four steps, landing at the crossing
      wr(3'h5, 8'h91);
      wr(3'h1, 8'h08);
      send(1, alc_pkg::ALC_LVL_FS6, 1'b1);
      vols(8'h90, 8'h91);
      send(1, alc_pkg::ALC_LVL_FS6, 1'b1);
      vols(8'h90, 8'h8D);
      $display("Test zero cross done");
      // Short burst arms fast recovery: quarter wait of 32 samples
      wr(3'h0, 8'h0B);
      wr(3'h2, 8'h00);
      wr(3'h5, 8'h80);
      // Quiet sample ends the long burst left over from earlier tests
      send(1, 26'h0001000, 1'b0);
      send(1, alc_pkg::ALC_LVL_M2P5, 1'b0);
      send(40, 26'h0001000, 1'b1);
      vols(8'h80, 8'h8D);
      rd(3'h6, 8'h02);
      $display("Test fast recovery done");
      results();
   end
endmodule // tb_top

/* File: pkg/alc_pkg.sv */
// Constants shared by the automatic level control engine
package alc_pkg;
   // Register offsets
   localparam logic [2:0] ALC_OFS_CTRL    = 3'h0;
   localparam logic [2:0] ALC_OFS_TUNE    = 3'h1;
   localparam logic [2:0] ALC_OFS_WAIT    = 3'h2;
   localparam logic [2:0] ALC_OFS_REC_REF = 3'h3;
   localparam logic [2:0] ALC_OFS_PLY_REF = 3'h4;
   localparam logic [2:0] ALC_OFS_VOLUME  = 3'h5;
   localparam logic [2:0] ALC_OFS_STATUS  = 3'h6;
   // Control register fields
   localparam int ALC_CTRL_PATH    = 0;
   localparam int ALC_CTRL_REC_EN  = 1;
   localparam int ALC_CTRL_PLAY_EN = 2;
   localparam int ALC_CTRL_ZC_DIS  = 3;
   localparam int ALC_CTRL_FAST_LM = 4;
   // Tuning register fields (two bits each)
   localparam int ALC_TUNE_THR  = 0;
   localparam int ALC_TUNE_ATT  = 2;
   localparam int ALC_TUNE_ZTO  = 4;
   localparam int ALC_TUNE_GAIN = 6;
   // Wait register fields
   localparam int ALC_WAIT_SEL  = 0;
   localparam int ALC_WAIT_FAST = 3;
   // Reset values
   localparam logic [7:0] ALC_CTRL_RST    = 8'h00;
   localparam logic [7:0] ALC_TUNE_RST    = 8'h00;
   localparam logic [7:0] ALC_WAIT_RST    = 8'h00;
   localparam logic [7:0] ALC_REC_REF_RST = 8'hE1;
   localparam logic [5:0] ALC_PLY_REF_RST = 6'h28;
   localparam logic [7:0] ALC_VOL_RST     = 8'h91;
   // Playback reference: 1.5 dB code to 0.375 dB code is 1 + 4*ref
   localparam logic [7:0] ALC_PLY_REF_OFS = 8'h01;
   // Sample periods
   localparam logic [10:0] ALC_ZTO_BASE  = 11'h080;
   localparam logic [14:0] ALC_WAIT_BASE = 15'h0080;
   // Magnitudes on a 27-bit signed scale, full scale = 2^23
   localparam int ALC_SMP_W = 27;
   localparam logic [25:0] ALC_LVL_M2P5 = 26'h05FFC3D;
   localparam logic [25:0] ALC_LVL_M4P1 = 26'h04FD634;
   localparam logic [25:0] ALC_LVL_M6P0 = 26'h0402620;
   localparam logic [25:0] ALC_LVL_M8P5 = 26'h0301B16;
   localparam logic [25:0] ALC_LVL_M12  = 26'h0202784;
   localparam logic [25:0] ALC_LVL_FS   = 26'h0800000;
   localparam logic [25:0] ALC_LVL_FS6  = 26'h0FF6630;
   localparam logic [25:0] ALC_LVL_FS12 = 26'h1FD93AE;
   // Impulse noise: limiting lasting at most this many samples
   localparam logic [7:0] ALC_IMPULSE_MAX = 8'h08;
endpackage
